/* File: rtl/e1_ctrl_pkg.sv */
// Package: register map, field positions, reset values and timing for E1 common control
package e1_ctrl_pkg;
	// Printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] IDX_COMMON_CONTROL_ONE = 8'h19;
	localparam logic [7:0] IDX_COMMON_CONTROL_TWO = 8'h1a;
	localparam logic [7:0] IDX_COMMON_CONTROL_THREE = 8'h1b;
	localparam logic [7:0] IDX_STATUS = 8'h1c;
	localparam logic [9:0] ADDR_COMMON_CONTROL_ONE = {IDX_COMMON_CONTROL_ONE, 2'b00};
	localparam logic [9:0] ADDR_COMMON_CONTROL_TWO = {IDX_COMMON_CONTROL_TWO, 2'b00};
	localparam logic [9:0] ADDR_COMMON_CONTROL_THREE = {IDX_COMMON_CONTROL_THREE, 2'b00};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

	localparam logic [7:0] RST_COMMON_CONTROL_ONE = 8'h00;
	localparam logic [7:0] RST_COMMON_CONTROL_TWO = 8'h00;
	localparam logic [7:0] RST_COMMON_CONTROL_THREE = 8'h00;

	// Field positions, common_control_one
	localparam int POS_FRAMER_LOOPBACK = 7;
	localparam int POS_RX_CRC4_ENABLE = 0;
	// Field positions, common_control_two
	localparam int POS_COUNTER_UPDATE_SELECT = 7;
	localparam int POS_VIOLATION_COUNT_SELECT = 6;
	localparam int POS_AUTO_AIS_ENABLE = 5;
	localparam int POS_AUTO_REMOTE_ALARM_ENABLE = 4;
	localparam int POS_RX_SERIAL_SQUELCH = 3;
	localparam int POS_TX_CLOCK_FALLBACK = 2;
	localparam int POS_RX_FORCE_FREEZE = 1;
	localparam int POS_RX_FREEZE_ENABLE = 0;
	// Field positions, common_control_three
	localparam int POS_TX_ELASTIC_ENABLE = 7;
	localparam int POS_TX_BLOCK_FUNCTION_SELECT = 6;
	localparam int POS_TX_IDLE_FUNCTION_SELECT = 5;
	localparam int POS_RX_SIGNALING_REINSERT = 3;
	localparam int POS_TX_HW_SIGNALING_INSERT = 2;
	localparam int POS_TX_BACKPLANE_CLOCK_SELECT = 1;
	localparam int POS_CARRIER_LOSS_ALT_CRITERIA = 0;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TX_CLOCK_STOP_NS = 2000;
	localparam logic [7:0] TX_CLOCK_STOP_CYCLES = 8'(TX_CLOCK_STOP_NS / CLK_PERIOD_NS);
	localparam int FRAME_PERIOD_US = 125;
	localparam int UPDATE_LONG_MS = 1000;
	localparam int UPDATE_SHORT_FRAMES = 500;
	localparam logic [12:0] UPDATE_LONG_COUNT = 13'(UPDATE_LONG_MS * 1000 / FRAME_PERIOD_US);
	localparam logic [12:0] UPDATE_SHORT_COUNT = 13'(UPDATE_SHORT_FRAMES);
	localparam int CRC4_ALARM_MS = 128;
	localparam int CRC4_CONTINUOUS_MS = 400;
	localparam logic [11:0] CRC4_ALARM_FRAMES = 12'(CRC4_ALARM_MS * 1000 / FRAME_PERIOD_US);
	localparam logic [11:0] CRC4_CONTINUOUS_FRAMES =
		12'(CRC4_CONTINUOUS_MS * 1000 / FRAME_PERIOD_US);
	localparam logic [11:0] CARRIER_ZEROS_NORMAL = 12'd255;
	localparam logic [11:0] CARRIER_ZEROS_ALT = 12'd2048;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

	// Static transmit-side selections handed to the formatter
	typedef struct packed {
		logic tx_elastic_enable;
		logic tx_block_function_select;
		logic tx_idle_function_select;
		logic tx_backplane_clock_select;
		logic tx_hw_signaling_insert;
	} tx_cfg_t;

	// Receive-side conditions from the framer
	typedef struct packed {
		logic frame_loss;
		logic ais_received;
		logic fas_sync;
		logic crc4_mf_sync;
	} rx_cond_t;

	typedef enum logic [2:0] {
		CRC_WAIT = 3'b001,
		CRC_HUNT = 3'b010,
		CRC_LOCK = 3'b100
	} crc_state_t;
endpackage

/* File: rtl/e1_framer_common_control.sv */
// E1 framer common control: registers, loopback, alarms, carrier loss, clock fallback
`timescale 1ns/100ps

module e1_framer_common_control
	import e1_ctrl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	// Line pins
	input wire logic i_rx_line_positive,
	input wire logic i_rx_line_negative,
	input wire logic i_rx_line_clock,
	input wire logic i_tx_line_clock,
	output logic o_tx_line_positive,
	output logic o_tx_line_negative,
	output logic o_rx_clock,
	output logic o_tx_formatter_clock,
	// Transmit formatter data, same clock
	input wire logic i_tx_positive,
	input wire logic i_tx_negative,
	// Receive data into the framer core
	output logic o_rx_core_positive,
	output logic o_rx_core_negative,
	// Framer core status, same clock
	input wire rx_cond_t i_rx_cond,
	input wire logic i_frame_pulse,
	input wire logic i_bipolar_violation,
	input wire logic i_code_violation,
	input wire logic i_rx_serial_in,
	input wire logic i_signaling_slot,
	input wire logic i_signaling_bit,
	input wire logic i_freeze_event,
	// Results
	output logic o_rx_serial_data,
	output logic o_count_violation,
	output logic o_counter_latch,
	output logic o_rx_carrier_loss,
	output logic o_tx_ais,
	output logic o_tx_remote_alarm,
	output logic o_rx_crc4_enable,
	output logic o_rx_signaling_frozen,
	output tx_cfg_t o_tx_cfg
);
	// ==========================================================
	// Register bus
	logic [7:0] common_control_one, next_common_control_one;
	logic [7:0] common_control_two, next_common_control_two;
	logic [7:0] common_control_three, next_common_control_three;
	logic wr_pend, next_wr_pend;
	logic [9:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic [7:0] status;
	logic addr_phase;

	assign addr_phase = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	always_comb begin
		next_common_control_one = common_control_one;
		next_common_control_two = common_control_two;
		next_common_control_three = common_control_three;
		next_wr_pend = addr_phase && i_hwrite;
		next_wr_addr = addr_phase ? i_haddr[9:0] : wr_addr;
		next_hrdata = 32'h0000_0000;
		if (wr_pend) begin
			unique case (wr_addr)
				ADDR_COMMON_CONTROL_ONE: next_common_control_one = i_hwdata[7:0];
				ADDR_COMMON_CONTROL_TWO: next_common_control_two = i_hwdata[7:0];
				ADDR_COMMON_CONTROL_THREE: next_common_control_three = i_hwdata[7:0];
				default: ;
			endcase
		end
		// Read of a word written in the previous data phase sees the new value
		if (addr_phase && !i_hwrite) begin
			unique case (i_haddr[9:0])
				ADDR_COMMON_CONTROL_ONE: next_hrdata = {24'h000000, next_common_control_one};
				ADDR_COMMON_CONTROL_TWO: next_hrdata = {24'h000000, next_common_control_two};
				ADDR_COMMON_CONTROL_THREE: next_hrdata = {24'h000000, next_common_control_three};
				ADDR_STATUS: next_hrdata = {24'h000000, status};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			common_control_one <= RST_COMMON_CONTROL_ONE;
			common_control_two <= RST_COMMON_CONTROL_TWO;
			common_control_three <= RST_COMMON_CONTROL_THREE;
			wr_pend <= 1'b0;
			wr_addr <= 10'h000;
			o_hrdata <= 32'h0000_0000;
		end else begin
			common_control_one <= next_common_control_one;
			common_control_two <= next_common_control_two;
			common_control_three <= next_common_control_three;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			o_hrdata <= next_hrdata;
		end
	end

	logic loopback, crc4_en, update_sel, viol_sel, auto_ais, auto_rai;
	logic squelch, fallback_en, force_freeze, freeze_en, reinsert, alt_criteria;
	assign loopback = common_control_one[POS_FRAMER_LOOPBACK];
	assign crc4_en = common_control_one[POS_RX_CRC4_ENABLE];
	assign update_sel = common_control_two[POS_COUNTER_UPDATE_SELECT];
	assign viol_sel = common_control_two[POS_VIOLATION_COUNT_SELECT];
	assign auto_ais = common_control_two[POS_AUTO_AIS_ENABLE];
	assign auto_rai = common_control_two[POS_AUTO_REMOTE_ALARM_ENABLE];
	assign squelch = common_control_two[POS_RX_SERIAL_SQUELCH];
	assign fallback_en = common_control_two[POS_TX_CLOCK_FALLBACK];
	assign force_freeze = common_control_two[POS_RX_FORCE_FREEZE];
	assign freeze_en = common_control_two[POS_RX_FREEZE_ENABLE];
	assign reinsert = common_control_three[POS_RX_SIGNALING_REINSERT];
	assign alt_criteria = common_control_three[POS_CARRIER_LOSS_ALT_CRITERIA];

	// ==========================================================
	// Pin synchronisers: four pins, two stages, third stage for edges
	logic [3:0] pin_in, sync_a, next_sync_a, sync_b, next_sync_b, sync_c, next_sync_c;
	assign pin_in = {i_tx_line_clock, i_rx_line_clock, i_rx_line_negative, i_rx_line_positive};

	always_comb begin
		next_sync_a = pin_in;
		next_sync_b = sync_a;
		next_sync_c = sync_b;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
			sync_c <= 4'h0;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
			sync_c <= next_sync_c;
		end
	end

	logic rx_pos_s, rx_neg_s, rx_clk_s, tx_clk_s, tx_clk_edge, rx_clk_rise;
	assign rx_pos_s = sync_b[0];
	assign rx_neg_s = sync_b[1];
	assign rx_clk_s = sync_b[2];
	assign tx_clk_s = sync_b[3];
	assign tx_clk_edge = sync_b[3] ^ sync_c[3];
	assign rx_clk_rise = sync_b[2] & ~sync_c[2];

	// ==========================================================
	// Line path, loopback and clock fallback
	logic [7:0] tx_idle_cnt, next_tx_idle_cnt;
	logic fallback, next_fallback;
	logic next_tx_pos, next_tx_neg, next_core_pos, next_core_neg;
	logic next_rx_clock, next_formatter_clock;

	always_comb begin
		next_tx_pos = i_tx_positive;
		next_tx_neg = i_tx_negative;
		// Receive pins dropped in loopback
		next_core_pos = loopback ? i_tx_positive : rx_pos_s;
		next_core_neg = loopback ? i_tx_negative : rx_neg_s;
		next_rx_clock = loopback ? tx_clk_s : rx_clk_s;
		next_tx_idle_cnt = tx_idle_cnt;
		if (tx_clk_edge) begin
			next_tx_idle_cnt = 8'h00;
		end else if (tx_idle_cnt != TX_CLOCK_STOP_CYCLES) begin
			next_tx_idle_cnt = tx_idle_cnt + 8'h01;
		end
		// Returns to the transmit clock as soon as it toggles again
		next_fallback = fallback_en && (next_tx_idle_cnt == TX_CLOCK_STOP_CYCLES);
		next_formatter_clock = fallback ? rx_clk_s : tx_clk_s;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_tx_line_positive <= 1'b0;
			o_tx_line_negative <= 1'b0;
			o_rx_core_positive <= 1'b0;
			o_rx_core_negative <= 1'b0;
			o_rx_clock <= 1'b0;
			o_tx_formatter_clock <= 1'b0;
			tx_idle_cnt <= 8'h00;
			fallback <= 1'b0;
		end else begin
			o_tx_line_positive <= next_tx_pos;
			o_tx_line_negative <= next_tx_neg;
			o_rx_core_positive <= next_core_pos;
			o_rx_core_negative <= next_core_neg;
			o_rx_clock <= next_rx_clock;
			o_tx_formatter_clock <= next_formatter_clock;
			tx_idle_cnt <= next_tx_idle_cnt;
			fallback <= next_fallback;
		end
	end

	// ==========================================================
	// Carrier loss: consecutive zeros at the receive clock
	logic [11:0] zero_cnt, next_zero_cnt;
	logic carrier_loss, next_carrier_loss;
	logic [11:0] zero_limit;
	logic line_mark;

	assign zero_limit = alt_criteria ? CARRIER_ZEROS_ALT : CARRIER_ZEROS_NORMAL;
	assign line_mark = next_core_pos | next_core_neg;

	always_comb begin
		next_zero_cnt = zero_cnt;
		if (rx_clk_rise) begin
			if (line_mark) begin
				next_zero_cnt = 12'h000;
			end else if (zero_cnt != CARRIER_ZEROS_ALT) begin
				next_zero_cnt = zero_cnt + 12'h001;
			end
		end
		next_carrier_loss = (next_zero_cnt >= zero_limit);
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			zero_cnt <= 12'h000;
			carrier_loss <= 1'b0;
		end else begin
			zero_cnt <= next_zero_cnt;
			carrier_loss <= next_carrier_loss;
		end
	end

	// ==========================================================
	// Counter update period and violation select
	logic [12:0] frame_cnt, next_frame_cnt;
	logic next_latch, next_viol;
	logic [12:0] update_limit;

	assign update_limit = update_sel ? UPDATE_SHORT_COUNT : UPDATE_LONG_COUNT;

	always_comb begin
		next_frame_cnt = frame_cnt;
		next_latch = 1'b0;
		if (i_frame_pulse) begin
			if (frame_cnt + 13'h0001 >= update_limit) begin
				next_frame_cnt = 13'h0000;
				next_latch = 1'b1;
			end else begin
				next_frame_cnt = frame_cnt + 13'h0001;
			end
		end
		next_viol = viol_sel ? i_code_violation : i_bipolar_violation;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			frame_cnt <= 13'h0000;
			o_counter_latch <= 1'b0;
			o_count_violation <= 1'b0;
		end else begin
			frame_cnt <= next_frame_cnt;
			o_counter_latch <= next_latch;
			o_count_violation <= next_viol;
		end
	end

	// ==========================================================
	// CRC4 multiframe search timer, counted in frames
	crc_state_t crc_state, next_crc_state;
	logic [11:0] crc_frames, next_crc_frames;
	logic crc_alarm, crc_continuous;

	always_comb begin
		next_crc_state = crc_state;
		next_crc_frames = crc_frames;
		unique case (crc_state)
			CRC_WAIT: begin
				next_crc_frames = 12'h000;
				if (crc4_en && i_rx_cond.fas_sync) begin
					next_crc_state = CRC_HUNT;
				end
			end
			CRC_HUNT: begin
				if (!crc4_en || !i_rx_cond.fas_sync) begin
					next_crc_state = CRC_WAIT;
				end else if (i_rx_cond.crc4_mf_sync) begin
					next_crc_state = CRC_LOCK;
				end else if (i_frame_pulse && crc_frames != CRC4_CONTINUOUS_FRAMES) begin
					next_crc_frames = crc_frames + 12'h001;
				end
			end
			CRC_LOCK: begin
				next_crc_frames = 12'h000;
				if (!crc4_en || !i_rx_cond.fas_sync || !i_rx_cond.crc4_mf_sync) begin
					next_crc_state = CRC_WAIT;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			crc_state <= CRC_WAIT;
			crc_frames <= 12'h000;
		end else begin
			crc_state <= next_crc_state;
			crc_frames <= next_crc_frames;
		end
	end

	assign crc_alarm = (crc_state == CRC_HUNT) && (crc_frames >= CRC4_ALARM_FRAMES);
	assign crc_continuous = (crc_state == CRC_HUNT) && (crc_frames >= CRC4_CONTINUOUS_FRAMES);

	// ==========================================================
	// Automatic alarms and receive serial output
	logic rx_defect;
	logic next_ais, next_rai, next_rx_serial_data, next_frozen;
	logic held_sig, next_held_sig, freezing;

	assign rx_defect = i_rx_cond.frame_loss | i_rx_cond.ais_received | carrier_loss;
	// Both enables at once is a host error; the freeze is still reported as set
	assign freezing = reinsert && (force_freeze || (freeze_en && i_freeze_event));

	always_comb begin
		next_ais = auto_ais && rx_defect;
		next_rai = auto_rai && (rx_defect || crc_alarm || crc_continuous);
		next_held_sig = held_sig;
		next_rx_serial_data = i_rx_serial_in;
		if (reinsert && i_signaling_slot) begin
			next_rx_serial_data = freezing ? held_sig : i_signaling_bit;
			if (!freezing) begin
				next_held_sig = i_signaling_bit;
			end
		end
		if (squelch && i_rx_cond.frame_loss) begin
			next_rx_serial_data = 1'b1;
		end
		next_frozen = freezing;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_tx_ais <= 1'b0;
			o_tx_remote_alarm <= 1'b0;
			o_rx_serial_data <= 1'b1;
			o_rx_signaling_frozen <= 1'b0;
			held_sig <= 1'b1;
		end else begin
			o_tx_ais <= next_ais;
			o_tx_remote_alarm <= next_rai;
			o_rx_serial_data <= next_rx_serial_data;
			o_rx_signaling_frozen <= next_frozen;
			held_sig <= next_held_sig;
		end
	end

	// ==========================================================
	// Static selections and status
	assign o_tx_cfg.tx_elastic_enable = common_control_three[POS_TX_ELASTIC_ENABLE];
	assign o_tx_cfg.tx_block_function_select =
		common_control_three[POS_TX_BLOCK_FUNCTION_SELECT];
	assign o_tx_cfg.tx_idle_function_select =
		common_control_three[POS_TX_IDLE_FUNCTION_SELECT];
	assign o_tx_cfg.tx_backplane_clock_select = common_control_three[POS_TX_BACKPLANE_CLOCK_SELECT];
	assign o_tx_cfg.tx_hw_signaling_insert = common_control_three[POS_TX_HW_SIGNALING_INSERT];
	assign o_rx_crc4_enable = crc4_en;
	assign o_rx_carrier_loss = carrier_loss;
	assign status = {3'b000, freezing, crc_continuous, crc_alarm, fallback, carrier_loss};
endmodule // e1_framer_common_control

/* File: tb/e1_framer_common_control_properties.sv */
// Checker: port-level properties of the E1 common control block
`timescale 1ns/100ps
module e1_ctrl_checker
	import e1_ctrl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic i_tx_line_clock,
	input wire logic o_tx_formatter_clock,
	input wire logic i_tx_positive,
	input wire logic o_tx_line_positive,
	input wire logic o_rx_core_positive,
	input wire rx_cond_t i_rx_cond,
	input wire logic i_bipolar_violation,
	input wire logic i_code_violation,
	input wire logic i_rx_serial_in,
	input wire logic o_rx_serial_data,
	input wire logic o_count_violation,
	input wire logic o_tx_ais,
	input wire logic o_rx_crc4_enable,
	input wire tx_cfg_t o_tx_cfg
);
	// ==========================================================
	// Shadow registers rebuilt from bus traffic
	logic [7:0] cc1, cc2, cc3, rd_val;
	logic [9:0] a_q;
	logic [2:0] ls;
	logic wr_q, rd_q, fb_seen, take;
	assign take = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
	assign rd_val = (a_q == ADDR_COMMON_CONTROL_ONE) ? cc1 :
		(a_q == ADDR_COMMON_CONTROL_TWO) ? cc2 :
		(a_q == ADDR_COMMON_CONTROL_THREE) ? cc3 : 8'h00;
	always_ff @(posedge i_clk) begin
		// Cycles since release; registered outputs lag their causes
		ls <= {ls[1:0], i_nrst};
		if (!i_nrst) begin
			{cc1, cc2, cc3, a_q, wr_q, rd_q, fb_seen} <= '0;
		end else begin
			wr_q <= take && i_hwrite;
			rd_q <= take && !i_hwrite && i_haddr[9:0] != ADDR_STATUS;
			if (take) a_q <= i_haddr[9:0];
			if (wr_q && a_q == ADDR_COMMON_CONTROL_ONE) cc1 <= i_hwdata[7:0];
			if (wr_q && a_q == ADDR_COMMON_CONTROL_TWO) cc2 <= i_hwdata[7:0];
			if (wr_q && a_q == ADDR_COMMON_CONTROL_THREE) cc3 <= i_hwdata[7:0];
			fb_seen <= fb_seen || cc2[2];
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	property p_tx_line; ls[0] |-> o_tx_line_positive == $past(i_tx_positive); endproperty
	a_tx_line: assert property (p_tx_line) else $error("tx line data lost");
	property p_loop; ls[0] && $past(cc1[7]) |-> o_rx_core_positive == $past(i_tx_positive);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback data wrong");
	property p_viol; ls[0] |-> o_count_violation ==
		($past(cc2[6]) ? $past(i_code_violation) : $past(i_bipolar_violation)); endproperty
	a_viol: assert property (p_viol) else $error("violation select wrong");
	property p_ais_on; ls[0] && $past(cc2[5] && (i_rx_cond.frame_loss ||
		i_rx_cond.ais_received)) |-> o_tx_ais; endproperty
	a_ais_on: assert property (p_ais_on) else $error("ais not sent");
	property p_ais_off; ls[0] && !$past(cc2[5]) |-> !o_tx_ais; endproperty
	a_ais_off: assert property (p_ais_off) else $error("ais sent while disabled");
	property p_squelch; ls[0] && $past(cc2[3] && i_rx_cond.frame_loss) |-> o_rx_serial_data;
	endproperty
	a_squelch: assert property (p_squelch) else $error("serial output not squelched");
	property p_pass; ls[0] && $past(!cc2[3] && !cc3[3]) |->
		o_rx_serial_data == $past(i_rx_serial_in); endproperty
	a_pass: assert property (p_pass) else $error("serial data altered");
	property p_read; rd_q |-> o_hrdata == {24'h0, rd_val}; endproperty
	a_read: assert property (p_read) else $error("read data wrong");
	property p_crc4; o_rx_crc4_enable == cc1[0]; endproperty
	a_crc4: assert property (p_crc4) else $error("crc4 enable wrong");
	property p_cfg; o_tx_cfg == {cc3[7], cc3[6], cc3[5], cc3[1], cc3[2]}; endproperty
	a_cfg: assert property (p_cfg) else $error("tx config wrong");
	property p_fallback; &ls && !fb_seen |->
		o_tx_formatter_clock == $past(i_tx_line_clock, 3); endproperty
	a_fallback: assert property (p_fallback) else $error("formatter clock switched");
	c_loop: cover property (ls[0] && cc1[7] && o_rx_core_positive);
	c_ais: cover property (o_tx_ais);
	c_read: cover property (rd_q && cc2 != 8'h00);
endmodule // e1_ctrl_checker

bind e1_framer_common_control e1_ctrl_checker i_e1_ctrl_checker (.*);

/* File: tb/e1_line_model.sv */
// Line interface model: receive and transmit line clocks, receive AMI data
`timescale 1ns/100ps
module e1_line_model (
	input wire logic i_rx_run,
	input wire logic i_tx_run,
	input wire logic i_zeros,
	output logic o_rx_line_clock,
	output logic o_tx_line_clock,
	output logic o_rx_line_positive,
	output logic o_rx_line_negative
);
	// ==========================================================
	// Clocks: odd offset keeps pin edges away from the core clock edges
	initial begin
		o_rx_line_clock = 1'b0;
		o_tx_line_clock = 1'b0;
		o_rx_line_positive = 1'b0;
		o_rx_line_negative = 1'b0;
		#1.3;
		forever begin
			#62.5;
			if (i_rx_run) o_rx_line_clock = ~o_rx_line_clock;
			if (i_tx_run) o_tx_line_clock = ~o_tx_line_clock;
		end
	end
	// Alternate marks, or a run of zeros for carrier loss
	always @(negedge o_rx_line_clock) begin
		o_rx_line_positive <= !i_zeros && !o_rx_line_positive;
		o_rx_line_negative <= !i_zeros && o_rx_line_positive;
	end
endmodule // e1_line_model

/* File: tb/tb_e1_framer_common_control.sv */
// Testbench: register, alarm, carrier, loopback and clock fallback tests
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb_e1_framer_common_control;
	import e1_ctrl_pkg::*;
	logic i_clk = 0, i_nrst = 0, i_hsel = 0, i_hwrite = 0, i_frame_pulse = 0;
	logic i_bipolar_violation = 0, i_code_violation = 0, i_rx_serial_in = 0;
	logic i_signaling_slot = 0, i_signaling_bit = 0, i_freeze_event = 0;
	logic i_tx_positive = 0, i_tx_negative = 0, rx_run = 1, tx_run = 1, zeros = 0;
	logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, rd;
	logic [1:0] i_htrans = 0;
	logic [2:0] i_hsize = 3'h2;
	rx_cond_t i_rx_cond = '0;
	wire logic i_hready, i_rx_line_positive, i_rx_line_negative, i_rx_line_clock, i_tx_line_clock;
	logic o_hreadyout, o_hresp, o_tx_line_positive, o_tx_line_negative, o_rx_clock;
	logic o_tx_formatter_clock, o_rx_core_positive, o_rx_core_negative, o_rx_serial_data;
	logic o_count_violation, o_counter_latch, o_rx_carrier_loss, o_tx_ais, o_tx_remote_alarm;
	logic o_rx_crc4_enable, o_rx_signaling_frozen;
	tx_cfg_t o_tx_cfg;
	int error_cnt = 0, comparisons = 0, latch_cnt = 0, cycles = 0, l0, n;
	assign i_hready = o_hreadyout;
	always #5 i_clk = ~i_clk;
	e1_framer_common_control i_e1_framer_common_control (.*);
	e1_line_model i_e1_line_model (.i_rx_run(rx_run), .i_tx_run(tx_run), .i_zeros(zeros),
		.o_rx_line_clock(i_rx_line_clock), .o_tx_line_clock(i_tx_line_clock),
		.o_rx_line_positive(i_rx_line_positive), .o_rx_line_negative(i_rx_line_negative));
	// ==========================================================
	// Tasks
	task tally_and_finish;
		if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cycles++;
		if (o_counter_latch === 1'b1) latch_cnt++;
		// Longest path is about 60k cycles
		if (cycles == 90000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_hsel <= 1'b1;
		i_htrans <= HTRANS_NONSEQ;
		i_haddr <= {22'h0, a};
		i_hwrite <= w;
		@(posedge i_clk);
		while (i_hready !== 1'b1) @(posedge i_clk);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		@(posedge i_clk);
		while (i_hready !== 1'b1) @(posedge i_clk);
		rd = o_hrdata;
	endtask
	task settle(input int k);
		repeat (k) @(posedge i_clk);
		@(negedge i_clk);
	endtask
	task frames(input int k);
		repeat (k) begin
			@(posedge i_clk) i_frame_pulse <= 1'b1;
			@(posedge i_clk) i_frame_pulse <= 1'b0;
		end
		settle(2);
	endtask
	task viol(input logic c);
		@(posedge i_clk);
		i_code_violation <= c;
		i_bipolar_violation <= !c;
		@(posedge i_clk);
		i_code_violation <= 1'b0;
		i_bipolar_violation <= 1'b0;
		@(negedge i_clk);
	endtask
	task toggles(input logic rxc);
		logic p;
		n = 0;
		p = rxc ? o_rx_clock : o_tx_formatter_clock;
		repeat (200) begin
			@(negedge i_clk);
			if ((rxc ? o_rx_clock : o_tx_formatter_clock) !== p) n++;
			p = rxc ? o_rx_clock : o_tx_formatter_clock;
		end
	endtask
	// ==========================================================
	// Sequence
	initial begin
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			bus(0, ADDR_COMMON_CONTROL_ONE + 10'(4 * i), 0);
			`CHK("reset value", 32'h0, rd)
		end
		bus(1, ADDR_COMMON_CONTROL_TWO, 32'hffff_ffdb);
		bus(0, ADDR_COMMON_CONTROL_TWO, 0);
		`CHK("ctl two", 32'h0000_00db, rd)
		bus(1, ADDR_COMMON_CONTROL_THREE, 32'h0000_00e9);
		bus(0, ADDR_COMMON_CONTROL_THREE, 0);
		`CHK("ctl three", 32'h0000_00e9, rd)
		`CHK("tx cfg", 5'b11100, o_tx_cfg)
		bus(1, 10'h3fc, 32'h0000_00ff);
		bus(0, 10'h3fc, 0);
		`CHK("unmapped", 32'h0, rd)
		bus(1, ADDR_COMMON_CONTROL_THREE, 32'h0000_0002);
		@(negedge i_clk);
		`CHK("backplane sel", 5'b00010, o_tx_cfg)
		// Fresh reset so the frame count starts from zero
		@(posedge i_clk) i_nrst <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		bus(1, ADDR_COMMON_CONTROL_TWO, 32'h80);
		l0 = latch_cnt;
		frames(499);
		`CHK("latch 499", 0, latch_cnt - l0)
		frames(1);
		`CHK("latch 500", 1, latch_cnt - l0)
		@(posedge i_clk) i_nrst <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		l0 = latch_cnt;
		frames(7999);
		`CHK("latch 7999", 0, latch_cnt - l0)
		frames(1);
		`CHK("latch 8000", 1, latch_cnt - l0)
		for (int s = 0; s < 2; s++) begin
			bus(1, ADDR_COMMON_CONTROL_TWO, {25'h0, s[0], 6'h0});
			viol(1'b0);
			`CHK("bpv", !s[0], o_count_violation)
			viol(1'b1);
			`CHK("cv", s[0], o_count_violation)
		end
		bus(1, ADDR_COMMON_CONTROL_TWO, 32'h20);
		for (int i = 0; i < 2; i++) begin
			@(posedge i_clk) i_rx_cond <= rx_cond_t'(4'b1000 >> i);
			settle(2);
			`CHK("ais", 1'b1, o_tx_ais)
		end
		@(posedge i_clk) i_rx_cond <= '0;
		zeros <= 1'b1;
		settle(3062);
		`CHK("carrier 245", 1'b0, o_rx_carrier_loss)
		settle(250);
		`CHK("carrier 265", 1'b1, o_rx_carrier_loss)
		`CHK("ais carrier", 1'b1, o_tx_ais)
		@(posedge i_clk) zeros <= 1'b0;
		settle(40);
		bus(1, ADDR_COMMON_CONTROL_THREE, 32'h01);
		@(posedge i_clk) zeros <= 1'b1;
		settle(25375);
		`CHK("carrier 2030", 1'b0, o_rx_carrier_loss)
		settle(500);
		`CHK("carrier 2070", 1'b1, o_rx_carrier_loss)
		@(posedge i_clk) zeros <= 1'b0;
		bus(1, ADDR_COMMON_CONTROL_THREE, 0);
		bus(1, ADDR_COMMON_CONTROL_TWO, 32'h10);
		@(posedge i_clk) i_rx_cond <= rx_cond_t'(4'b1000);
		settle(2);
		`CHK("rai sync", 1'b1, o_tx_remote_alarm)
		`CHK("ais off", 1'b0, o_tx_ais)
		bus(1, ADDR_COMMON_CONTROL_ONE, 32'h01);
		@(negedge i_clk);
		`CHK("crc4 en", 1'b1, o_rx_crc4_enable)
		@(posedge i_clk) i_rx_cond <= rx_cond_t'(4'b0010);
		frames(1020);
		`CHK("rai 1020", 1'b0, o_tx_remote_alarm)
		frames(10);
		`CHK("rai 1030", 1'b1, o_tx_remote_alarm)
		frames(2180);
		`CHK("rai 3210", 1'b1, o_tx_remote_alarm)
		bus(0, ADDR_STATUS, 0);
		`CHK("crc 400", 32'h0c, rd)
		bus(1, ADDR_COMMON_CONTROL_ONE, 0);
		frames(1100);
		`CHK("rai no crc4", 1'b0, o_tx_remote_alarm)
		bus(1, ADDR_COMMON_CONTROL_TWO, 32'h08);
		@(posedge i_clk) i_rx_cond <= rx_cond_t'(4'b1000);
		settle(2);
		`CHK("squelch", 1'b1, o_rx_serial_data)
		@(posedge i_clk) i_rx_cond <= '0;
		bus(1, ADDR_COMMON_CONTROL_TWO, 0);
		bus(1, ADDR_COMMON_CONTROL_THREE, 32'h08);
		@(posedge i_clk) i_signaling_slot <= 1'b1;
		i_signaling_bit <= 1'b1;
		settle(2);
		`CHK("reinsert", 1'b1, o_rx_serial_data)
		bus(1, ADDR_COMMON_CONTROL_TWO, 32'h02);
		@(posedge i_clk) i_signaling_bit <= 1'b0;
		settle(2);
		`CHK("force freeze", 1'b1, o_rx_serial_data)
		`CHK("frozen", 1'b1, o_rx_signaling_frozen)
		bus(1, ADDR_COMMON_CONTROL_TWO, 0);
		@(posedge i_clk) i_freeze_event <= 1'b1;
		settle(2);
		`CHK("no freeze", 1'b0, o_rx_serial_data)
		bus(1, ADDR_COMMON_CONTROL_TWO, 32'h01);
		@(posedge i_clk) i_signaling_bit <= 1'b1;
		settle(2);
		`CHK("freeze", 1'b0, o_rx_serial_data)
		bus(1, ADDR_COMMON_CONTROL_THREE, 0);
		@(posedge i_clk) i_rx_serial_in <= 1'b1;
		settle(2);
		`CHK("no reinsert", 1'b1, o_rx_serial_data)
		bus(1, ADDR_COMMON_CONTROL_ONE, 32'h80);
		@(posedge i_clk) i_tx_positive <= 1'b1;
		rx_run <= 1'b0;
		settle(2);
		`CHK("loop data", 1'b1, o_rx_core_positive)
		`CHK("line out", 1'b1, o_tx_line_positive)
		toggles(1'b1);
		`CHK("loop clock", 1'b1, n > 0)
		@(posedge i_clk) rx_run <= 1'b1;
		bus(1, ADDR_COMMON_CONTROL_ONE, 0);
		bus(1, ADDR_COMMON_CONTROL_TWO, 0);
		@(posedge i_clk) tx_run <= 1'b0;
		settle(300);
		toggles(1'b0);
		`CHK("no fallback", 0, n)
		bus(1, ADDR_COMMON_CONTROL_TWO, 32'h04);
		settle(300);
		toggles(1'b0);
		`CHK("fallback", 1'b1, n > 0)
		tally_and_finish();
	end
endmodule // tb_e1_framer_common_control
